/* rtl/pcbi_pkg.sv */
// Purpose: Shared types and constants for the expansion card bus interface.
// Assumes: Memory controller clock MCLK at 250 MHz (4 ns period).
// Notes: Pulse widths are given in ns and converted to whole clock cycles here.
package pcbi_pkg;

  // Clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 4000;

  // Card cycle timing in ns (least times, rounded up to cycles)
  localparam int unsigned SETUP_NS = 30;
  localparam int unsigned STROBE_NS = 100;
  localparam int unsigned HOLD_NS = 20;
  localparam int unsigned SETUP_CYC = (SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned STROBE_CYC = (STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned HOLD_CYC = (HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Widths
  localparam int unsigned ADDR_W = 26;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned LANE_W = 2;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned FIFO_DEPTH = 8;

  // Lane enable bit positions
  localparam int unsigned LANE_LO = 0;
  localparam int unsigned LANE_HI = 1;

  // Idle levels of the pins, and counter constants
  localparam logic [LANE_W-1:0] LANES_OFF_N = 2'h3;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 26'h000_0000;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  // Target space of a card transfer
  typedef enum logic [1:0] {
    PCBI_SP_MEM  = 2'h0,
    PCBI_SP_ATTR = 2'h1,
    PCBI_SP_IO   = 2'h2
  } pcbi_space_t;

  // One queued request from the memory controller
  typedef struct packed {
    pcbi_space_t space;
    logic write;
    logic socket;
    logic [LANE_W-1:0] lanes;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pcbi_req_t;

  // Completion returned for each request
  typedef struct packed {
    logic write;
    logic io_wide;
    logic [DATA_W-1:0] rdata;
  } pcbi_rsp_t;

endpackage : pcbi_pkg

/* rtl/pcbi_fifo.sv */
// Purpose: Synchronous FIFO with valid/ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes: Pointers carry one extra bit so full and empty are exact.
`timescale 1ns/1ps
`default_nettype none
module pcbi_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW:0] wr_ptr_r;
  logic [PW:0] rd_ptr_r;
  wire logic push;
  wire logic pop;
  wire logic full;
  wire logic empty;

  // Full when pointers differ only in the wrap bit
  assign full = (wr_ptr_r[PW] != rd_ptr_r[PW]) && (wr_ptr_r[PW-1:0] == rd_ptr_r[PW-1:0]);
  assign empty = (wr_ptr_r == rd_ptr_r);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign push = in_valid && !full;
  assign pop = out_ready && !empty;
  assign out_data = mem_r[rd_ptr_r[PW-1:0]];

  // Storage needs no reset; only pointers decide what is valid
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r[PW-1:0]] <= in_data;
    end
  end

  // Pointer update
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + (PW+1)'(push);
      rd_ptr_r <= rd_ptr_r + (PW+1)'(pop);
    end
  end
endmodule : pcbi_fifo
`default_nettype wire

/* rtl/pcbi_top.sv */
// Purpose: Expansion card bus interface: runs queued card cycles on the card pins.
// Assumes: Requests come from logic on MCLK; card pins are asynchronous to it.
// Notes: One transfer at a time; wait and width acknowledge pass two flops first.
// Overview of operation
// [R01] On reads the direction output is high and the data bus is left undriven for the card to drive.
// [R02] On writes the direction output is low and all 32 data lines are driven by this block.
// [R03] Reads of card memory and attribute space use the card output enable strobe.
// [R04] Writes to card memory and attribute space use the card write enable strobe.
// [R05] Writes to card I/O space use their own I/O write strobe.
// [R06] Reads from card I/O space use their own I/O read strobe.
// [R07] Two lane enables select the high byte lane (bit 1) and low byte lane (bit 0) independently.
// [R08] The card pulls the wide acknowledge low when it can do 16-bit I/O, and this block samples it.
// [R09] The card may hold wait low, and the strobe phase is stretched for as long as it does.
// [R10] Socket select is low for socket zero and high for socket one.
// [R11] Socket select changes at exactly the same edge as the address lines.
// [R12] On memory cycles the attribute select output is asserted when the target is attribute space, timed like address.
// [R13] All strobes, enables, acknowledge and wait signals named with a trailing _n are active low.
`timescale 1ns/1ps
`default_nettype none
module pcbi_top
  import pcbi_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // Request queue from the memory controller
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire pcbi_req_t REQ_CMD,
  // Completion of each transfer
  output logic RSP_VALID,
  output pcbi_rsp_t RSP_INFO,
  output logic BUSY,
  // Address and data bus
  output logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] DATA_IN,
  output logic [DATA_W-1:0] DATA_OUT,
  output logic DATA_OE,
  output logic TRANSFER_DIRECTION,
  // Card strobes and selects
  output logic CARD_OUTPUT_ENABLE_N,
  output logic CARD_WRITE_ENABLE_N,
  output logic CARD_IO_READ_N,
  output logic CARD_IO_WRITE_N,
  output logic [LANE_W-1:0] CARD_LANE_ENABLE_N,
  output logic SOCKET_SELECT,
  output logic ATTRIBUTE_SPACE_SELECT_N,
  // Card status inputs
  input wire logic CARD_IO_WIDE_ACK_N,
  input wire logic CARD_WAIT_N
);

  typedef enum {
    PCBI_IDLE,
    PCBI_SETUP,
    PCBI_STROBE,
    PCBI_HOLD
  } pcbi_state_t;

  localparam logic [CNT_W-1:0] SETUP_LAST = CNT_W'(SETUP_CYC);
  localparam logic [CNT_W-1:0] STROBE_LAST = CNT_W'(STROBE_CYC);
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYC);

  pcbi_state_t state_r;
  pcbi_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  pcbi_req_t cur_r;
  logic wait_s1_r;
  logic wait_s2_r;
  logic wide_s1_r;
  logic wide_s2_r;
  logic [DATA_W-1:0] din_s1_r;
  logic [DATA_W-1:0] din_s2_r;
  logic wide_seen_r;
  logic [ADDR_W-1:0] addr_r;
  logic sock_r;
  logic attr_n_r;
  logic dir_r;
  logic oe_r;
  logic [DATA_W-1:0] dout_r;
  logic poe_n_r;
  logic pwe_n_r;
  logic pior_n_r;
  logic piow_n_r;
  logic [LANE_W-1:0] lane_n_r;
  logic rsp_valid_r;
  pcbi_rsp_t rsp_r;

  wire logic q_valid;
  wire logic q_ready;
  pcbi_req_t q_cmd;

  // Eight-deep request queue; it drains only while idle, so a slow card backs up the requester
  pcbi_fifo #(
    .WIDTH($bits(pcbi_req_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_req_fifo (
    .clk(MCLK),
    .rst(SYS_RST),
    .in_valid(REQ_VALID),
    .in_ready(REQ_READY),
    .in_data(REQ_CMD),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_cmd)
  );

  // Decode of the transfer held in cur_r
  wire logic is_io;
  wire logic is_attr;
  wire logic take;
  wire logic strobe_done;
  wire logic setup_done;
  wire logic hold_done;
  wire logic enter_setup;
  wire logic enter_strobe;
  wire logic enter_hold;
  wire logic enter_idle;
  wire logic in_strobe_nxt;
  wire logic wait_held;

  assign is_io = (cur_r.space == PCBI_SP_IO);
  assign is_attr = (cur_r.space == PCBI_SP_ATTR);
  assign q_ready = (state_r == PCBI_IDLE);
  assign take = q_valid && q_ready;
  assign wait_held = !wait_s2_r; // Low wait from the card [R09] [R13]
  assign setup_done = (cnt_r >= SETUP_LAST);
  assign strobe_done = (cnt_r >= STROBE_LAST) && !wait_held; // Stretch while wait is low [R09]
  assign hold_done = (cnt_r >= HOLD_LAST);

  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PCBI_IDLE: begin
        if (take) begin
          state_nxt = PCBI_SETUP;
        end
      end
      PCBI_SETUP: begin
        if (setup_done) begin
          state_nxt = PCBI_STROBE;
        end
      end
      PCBI_STROBE: begin
        if (strobe_done) begin
          state_nxt = PCBI_HOLD;
        end
      end
      PCBI_HOLD: begin
        if (hold_done) begin
          state_nxt = PCBI_IDLE;
        end
      end
      default: begin
        state_nxt = PCBI_IDLE;
      end
    endcase
  end

  assign enter_setup = (state_r == PCBI_IDLE) && (state_nxt == PCBI_SETUP);
  assign enter_strobe = (state_r == PCBI_SETUP) && (state_nxt == PCBI_STROBE);
  assign enter_hold = (state_r == PCBI_STROBE) && (state_nxt == PCBI_HOLD);
  assign enter_idle = (state_r == PCBI_HOLD) && (state_nxt == PCBI_IDLE);
  assign in_strobe_nxt = (state_nxt == PCBI_STROBE);
  // Phase counter restarts on every state change, so each phase is counted alone
  assign cnt_nxt = (state_nxt != state_r) ? CNT_ONE : (cnt_r + CNT_ONE);

  // State, counter and captured request
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      state_r <= PCBI_IDLE;
      cnt_r <= CNT_ZERO;
      cur_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= (state_nxt == PCBI_IDLE) ? CNT_ZERO : cnt_nxt;
      if (take) begin
        cur_r <= q_cmd;
      end
    end
  end

  // Two-flop synchronisers for the asynchronous card inputs
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      wait_s1_r <= 1'b1;
      wait_s2_r <= 1'b1;
      wide_s1_r <= 1'b1;
      wide_s2_r <= 1'b1;
      din_s1_r <= DATA_ZERO;
      din_s2_r <= DATA_ZERO;
    end else begin
      wait_s1_r <= CARD_WAIT_N;
      wait_s2_r <= wait_s1_r;
      wide_s1_r <= CARD_IO_WIDE_ACK_N;
      wide_s2_r <= wide_s1_r;
      din_s1_r <= DATA_IN;
      din_s2_r <= din_s1_r;
    end
  end

  // Wide acknowledge is latched if seen low at any time during the strobe phase
  always_ff @(posedge MCLK) begin
    if (SYS_RST || enter_setup) begin
      wide_seen_r <= 1'b0;
    end else if (state_r == PCBI_STROBE && !wide_s2_r) begin
      wide_seen_r <= 1'b1; // Card accepts 16-bit I/O [R08] [R13]
    end
  end

  // Address, socket and attribute select all launch on one edge and hold to idle
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      addr_r <= ADDR_ZERO;
      sock_r <= 1'b0;
      attr_n_r <= 1'b1;
    end else if (take) begin
      addr_r <= q_cmd.addr;
      sock_r <= q_cmd.socket; // Same edge as address [R10] [R11]
      attr_n_r <= !(q_cmd.space == PCBI_SP_ATTR); // Low only for attribute memory [R12] [R13]
    end else if (enter_idle) begin
      attr_n_r <= 1'b1;
    end
  end

  // Data bus direction and drive, held across the whole transfer
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      dir_r <= 1'b1;
      oe_r <= 1'b0;
      dout_r <= DATA_ZERO;
    end else if (take) begin
      dir_r <= !q_cmd.write; // High on reads [R01], low on writes [R02]
      oe_r <= q_cmd.write; // Drive only for writes [R01] [R02]
      dout_r <= q_cmd.write ? q_cmd.wdata : DATA_ZERO;
    end else if (enter_idle) begin
      dir_r <= 1'b1; // Park as read so nothing fights the card between cycles
      oe_r <= 1'b0;
    end
  end

  // Strobes are registered from the next state so the pins never glitch
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      poe_n_r <= 1'b1;
      pwe_n_r <= 1'b1;
      pior_n_r <= 1'b1;
      piow_n_r <= 1'b1;
    end else begin
      poe_n_r <= !(in_strobe_nxt && !is_io && !cur_r.write); // Memory and attribute reads [R03] [R13]
      pwe_n_r <= !(in_strobe_nxt && !is_io && cur_r.write); // Memory and attribute writes [R04] [R13]
      pior_n_r <= !(in_strobe_nxt && is_io && !cur_r.write); // I/O reads [R06] [R13]
      piow_n_r <= !(in_strobe_nxt && is_io && cur_r.write); // I/O writes [R05] [R13]
    end
  end

  // Lane enables cover setup, strobe and hold so the card sees a clean select
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      lane_n_r <= LANES_OFF_N;
    end else if (take) begin
      lane_n_r[LANE_HI] <= !q_cmd.lanes[LANE_HI]; // High byte lane [R07] [R13]
      lane_n_r[LANE_LO] <= !q_cmd.lanes[LANE_LO]; // Low byte lane [R07] [R13]
    end else if (enter_idle) begin
      lane_n_r <= LANES_OFF_N;
    end
  end

  // Completion: read data comes from the synchronised bus, sampled as the strobe ends
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      rsp_valid_r <= 1'b0;
      rsp_r <= '0;
    end else begin
      rsp_valid_r <= enter_idle;
      if (enter_hold) begin
        rsp_r.write <= cur_r.write;
        rsp_r.io_wide <= wide_seen_r || !wide_s2_r; // Reported to the requester [R08]
        rsp_r.rdata <= cur_r.write ? DATA_ZERO : din_s2_r; // Card drove the bus [R01]
      end
    end
  end

  // Pins and status
  assign ADDR = addr_r;
  assign SOCKET_SELECT = sock_r;
  assign ATTRIBUTE_SPACE_SELECT_N = attr_n_r;
  assign TRANSFER_DIRECTION = dir_r;
  assign DATA_OE = oe_r;
  assign DATA_OUT = dout_r;
  assign CARD_OUTPUT_ENABLE_N = poe_n_r;
  assign CARD_WRITE_ENABLE_N = pwe_n_r;
  assign CARD_IO_READ_N = pior_n_r;
  assign CARD_IO_WRITE_N = piow_n_r;
  assign CARD_LANE_ENABLE_N = lane_n_r;
  assign RSP_VALID = rsp_valid_r;
  assign RSP_INFO = rsp_r;
  assign BUSY = (state_r != PCBI_IDLE) || q_valid;

endmodule : pcbi_top
`default_nettype wire

/* dv/pcbi_card_model.sv */
// Purpose: Behavioural card wired straight to the card pins of the block.
// Assumes: Strobes are active low and come straight from the block.
// Notes: Released data shows the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none
module pcbi_card_model (
  // Clock
  input wire logic clk,
  // Strobes from the block
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic ior_n,
  input wire logic iow_n,
  // Bench controls
  input wire logic [31:0] word,
  input wire logic stall,
  input wire logic wide,
  // Card outputs
  output logic [31:0] data,
  output logic wait_n,
  output logic wide_n
);
  logic [31:0] last_r;
  // Last value seen, so a released bus never holds still
  always_ff @(posedge clk) begin
    last_r <= data;
  end
  // Card drives the data bus only while a read strobe is low
  assign data = (!oe_n || !ior_n) ? word : ~last_r;
  // Wait held low during the strobe for as long as the bench asks
  assign wait_n = !(stall && !(oe_n & we_n & ior_n & iow_n));
  // Wide acknowledge given on I/O cycles when allowed
  assign wide_n = !(wide && !(ior_n & iow_n));
endmodule : pcbi_card_model
`default_nettype wire

/* dv/pcbi_top_chk.sv */
// Purpose: Port checker for the card bus interface.
// Assumes: One clock, synchronous active high reset.
// Notes: Bound to every pcbi_top instance.
`timescale 1ns/1ps
`default_nettype none
module pcbi_top_chk
  import pcbi_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // Bus outputs
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic DATA_OE,
  input wire logic TRANSFER_DIRECTION,
  // Strobes and selects
  input wire logic CARD_OUTPUT_ENABLE_N,
  input wire logic CARD_WRITE_ENABLE_N,
  input wire logic CARD_IO_READ_N,
  input wire logic CARD_IO_WRITE_N,
  input wire logic [LANE_W-1:0] CARD_LANE_ENABLE_N,
  input wire logic SOCKET_SELECT,
  input wire logic ATTRIBUTE_SPACE_SELECT_N,
  // Card input
  input wire logic CARD_WAIT_N
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // Strobe groups
  wire rd_n = CARD_OUTPUT_ENABLE_N & CARD_IO_READ_N;
  wire wr_n = CARD_WRITE_ENABLE_N & CARD_IO_WRITE_N;
  wire str_n = rd_n & wr_n;
  a_read_dir: assert property (!rd_n |-> TRANSFER_DIRECTION && !DATA_OE)
    else $error("read strobe without read direction");
  a_write_dir: assert property (!wr_n |-> !TRANSFER_DIRECTION && DATA_OE)
    else $error("write strobe without driven bus");
  a_one_strobe: assert property ($onehot0(~{CARD_OUTPUT_ENABLE_N, CARD_WRITE_ENABLE_N,
    CARD_IO_READ_N, CARD_IO_WRITE_N})) else $error("more than one strobe low");
  a_addr_stable: assert property (!str_n && !$past(str_n) |-> $stable(ADDR) && $stable(SOCKET_SELECT))
    else $error("address or socket moved in strobe");
  a_sock_addr: assert property ($changed(SOCKET_SELECT) |-> $changed(ADDR))
    else $error("socket moved apart from address");
  // Wait reaches the phase logic two edges late, so the pin two edges back decides the next strobe
  a_wait_hold: assert property (!str_n && !$past(CARD_WAIT_N, 2) |=> !str_n)
    else $error("strobe ended while wait low");
  a_attr_no_io: assert property (!ATTRIBUTE_SPACE_SELECT_N |-> CARD_IO_READ_N && CARD_IO_WRITE_N)
    else $error("attribute select on io cycle");
  a_lane_on: assert property (!str_n |-> CARD_LANE_ENABLE_N != LANES_OFF_N)
    else $error("strobe with no lane enabled");
  c_read: cover property (!rd_n);
  c_write: cover property (!wr_n);
  c_stall: cover property (!str_n && !CARD_WAIT_N);
endmodule : pcbi_top_chk
bind pcbi_top pcbi_top_chk i_chk (
  .MCLK(MCLK),
  .SYS_RST(SYS_RST),
  .ADDR(ADDR),
  .DATA_OE(DATA_OE),
  .TRANSFER_DIRECTION(TRANSFER_DIRECTION),
  .CARD_OUTPUT_ENABLE_N(CARD_OUTPUT_ENABLE_N),
  .CARD_WRITE_ENABLE_N(CARD_WRITE_ENABLE_N),
  .CARD_IO_READ_N(CARD_IO_READ_N),
  .CARD_IO_WRITE_N(CARD_IO_WRITE_N),
  .CARD_LANE_ENABLE_N(CARD_LANE_ENABLE_N),
  .SOCKET_SELECT(SOCKET_SELECT),
  .ATTRIBUTE_SPACE_SELECT_N(ATTRIBUTE_SPACE_SELECT_N),
  .CARD_WAIT_N(CARD_WAIT_N)
);
`default_nettype wire

/* dv/pcbi_top_tb.sv */
// Purpose: Self-checking bench for pcbi_top.
// Assumes: Card model answers reads, stalls only on request.
// Notes: Inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module pcbi_top_tb;
  import pcbi_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  pcbi_req_t req_cmd = '0;
  logic stall = 1'b0;
  logic wide = 1'b0;
  logic [DATA_W-1:0] word = DATA_ZERO;
  logic req_ready, rsp_valid, busy, data_oe, dir, oe_n, we_n, ior_n, iow_n, sock, attr_n, wait_n, wide_n;
  pcbi_rsp_t rsp_info;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data_in, data_out;
  logic [LANE_W-1:0] lane_n;
  int fail_count = 0;
  int n_checks = 0;
  wire logic [3:0] strb = {oe_n, we_n, ior_n, iow_n};
  pcbi_top i_dut (.MCLK(clk), .SYS_RST(rst), .REQ_VALID(req_valid), .REQ_READY(req_ready),
    .REQ_CMD(req_cmd), .RSP_VALID(rsp_valid), .RSP_INFO(rsp_info), .BUSY(busy), .ADDR(addr),
    .DATA_IN(data_in), .DATA_OUT(data_out), .DATA_OE(data_oe), .TRANSFER_DIRECTION(dir),
    .CARD_OUTPUT_ENABLE_N(oe_n), .CARD_WRITE_ENABLE_N(we_n), .CARD_IO_READ_N(ior_n),
    .CARD_IO_WRITE_N(iow_n), .CARD_LANE_ENABLE_N(lane_n), .SOCKET_SELECT(sock),
    .ATTRIBUTE_SPACE_SELECT_N(attr_n), .CARD_IO_WIDE_ACK_N(wide_n), .CARD_WAIT_N(wait_n));
  pcbi_card_model i_card (.clk(clk), .oe_n(oe_n), .we_n(we_n), .ior_n(ior_n), .iow_n(iow_n),
    .word(word), .stall(stall), .wide(wide), .data(data_in), .wait_n(wait_n), .wide_n(wide_n));
  // 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // Request held until taken at an edge with ready high
  task automatic send(input pcbi_req_t c);
    req_cmd = c;
    req_valid = 1'b1;
    while (req_ready !== 1'b1) tick(1);
    tick(1);
    req_valid = 1'b0;
  endtask : send
  task automatic get_rsp(output pcbi_rsp_t r);
    int k;
    k = 0;
    while (rsp_valid !== 1'b1 && k < 300) begin
      tick(1);
      k++;
    end
    `CHK(rsp_valid, 1'b1)
    r = rsp_info;
    tick(1);
  endtask : get_rsp
  task automatic t_reset();
    `CHK({strb, lane_n, attr_n, dir, data_oe}, 9'h1fe)
    `CHK({req_ready, busy, rsp_valid, sock, addr}, {4'h8, ADDR_ZERO})
    $display("test reset done");
  endtask : t_reset
  // Every space and direction, one stalled by wait
  task automatic t_spaces();
    pcbi_req_t c;
    pcbi_rsp_t r;
    int n;
    for (int i = 0; i < 6; i++) begin
      c = '0;
      c.space = pcbi_space_t'(i / 2);
      c.write = 1'(i % 2);
      c.socket = 1'(i / 2 % 2) ^ c.write;
      c.lanes = 2'(i % 3 + 1);
      c.addr = 26'(i * 17 + 1);
      c.wdata = 32'h1234_0000 | 32'(i);
      word = 32'ha5c3_0000 | 32'(i);
      wide = (i == 4);
      stall = (i == 1);
      send(c);
      n = 0;
      while (strb === 4'hf && n < 40) begin
        tick(1);
        n++;
      end
      `CHK(strb, 4'hf ^ (4'h8 >> (2 * (i / 4) + i % 2)))
      `CHK(dir, ~c.write)
      `CHK(data_oe, c.write)
      if (c.write) `CHK(data_out, c.wdata)
      `CHK(sock, c.socket)
      `CHK(addr, c.addr)
      `CHK(attr_n, i / 2 != 1)
      `CHK(lane_n, ~c.lanes)
      n = 0;
      while (strb !== 4'hf && n < 100) begin
        if (n == 40) stall = 1'b0;
        tick(1);
        n++;
      end
      if (i == 1) `CHK(n > 40, 1'b1) else `CHK(n, 25)
      get_rsp(r);
      `CHK(r.write, c.write)
      if (!c.write) `CHK(r.rdata, word)
      `CHK(r.io_wide, wide)
    end
    wide = 1'b0;
    $display("test spaces done");
  endtask : t_spaces
  // Queue filled until refused, then drained
  task automatic t_fill();
    pcbi_req_t c;
    pcbi_rsp_t r;
    int acc;
    int seen;
    logic ok;
    acc = 0;
    seen = 0;
    c = '0;
    c.write = 1'b1;
    c.lanes = 2'h3;
    req_valid = 1'b1;
    for (int k = 0; k < 12; k++) begin
      c.addr = 26'(acc + 256);
      req_cmd = c;
      ok = (req_ready === 1'b1);
      tick(1);
      acc += int'(ok);
    end
    `CHK(acc, 9)
    // The refused request stays offered; the first completion passes while it waits
    while (req_ready !== 1'b1) begin
      tick(1);
      seen += int'(rsp_valid === 1'b1);
    end
    tick(1);
    req_valid = 1'b0;
    `CHK(seen, 1)
    for (int k = 0; k < 9; k++) begin
      get_rsp(r);
      `CHK(r.write, 1'b1)
    end
    `CHK({busy, dir, data_oe}, 3'h2)
    $display("test fill done");
  endtask : t_fill
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  initial begin
    tick(3);
    rst = 1'b0;
    t_reset();
    t_spaces();
    t_fill();
    conclude();
  end
  // Tests need about 1000 cycles; ten times that is a hang
  initial begin
    #40000;
    fail_count++;
    conclude();
  end
endmodule : pcbi_top_tb
`default_nettype wire
